// File: include/acs_pkg.sv
// package: constants and types of the conversion sequencer
package acs_pkg;
	// core clock period and converter clock floor
	localparam int CORE_PERIOD_PS = 10000;
	localparam int ADCLK_MIN_PS = 33300;
	localparam int ADCLK_MIN_CYC =
		(ADCLK_MIN_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
	// phase lengths: core cycles or converter periods
	localparam int START_CYC = 2;
	localparam int SAMPLE_MIN = 2;
	localparam int SAMPLE_MAX = 32;
	localparam int CONV_TICKS = 10;
	localparam int LOAD_CYC = 2;
	localparam int IRQ_CYC = 2;
	// floor on the whole conversion
	localparam int TOTAL_MIN_PS = 500000;
	localparam int TOTAL_MIN_CYC =
		(TOTAL_MIN_PS + CORE_PERIOD_PS - 1) / CORE_PERIOD_PS;
	// widths
	localparam int RES_W = 10;
	localparam int WIN_W = 5;
	// reset values
	localparam logic [RES_W-1:0] RESULT_RST = 10'h000;
	localparam logic [7:0] CNT_RST = 8'h00;

	// sequencer states
	typedef enum logic [2:0] {
		ACS_IDLE,
		ACS_START,
		ACS_SAMPLE,
		ACS_CONV,
		ACS_LOAD,
		ACS_FLAG
	} acs_state_t;
endpackage

// File: include/acs_div_if.sv
// interface: restart and tick between sequencer and prescaler
`timescale 1ns/10ps
interface acs_div_if;
	logic restart; // realign the converter clock
	logic tick; // one core cycle per converter period
	modport seq (output restart, input tick);
	modport div (input restart, output tick);
endinterface

// File: hw/acs_prescaler.sv
// module: converter clock prescaler, one tick per period
`timescale 1ns/10ps
module acs_prescaler
	import acs_pkg::*;
#(
	parameter int DIV = ADCLK_MIN_CYC
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// link to the sequencer
	acs_div_if.div bus
);
	// state: period counter and registered tick
	typedef struct packed {
		logic [7:0] cnt;
		logic tick;
	} acs_div_t;

	acs_div_t s_r;
	acs_div_t s_nxt;

	// a shorter period would clock the converter too fast
	initial begin
		if (DIV < ADCLK_MIN_CYC || DIV > 255) begin
			$error("acs_prescaler: DIV out of range");
		end
	end

	// next state: restart counts its own cycle so a phase
	// started with it lasts whole periods exactly
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (bus.restart) begin
			s_nxt.cnt = 8'h01;
		end else if (s_r.cnt == 8'(DIV - 1)) begin
			s_nxt.cnt = CNT_RST;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 8'h01;
		end
	end

	// state register
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bus.tick = s_r.tick;

	// ticks never come closer than the floor period
	a_tick_gap: assert property (@(posedge i_core_clk)
		disable iff (!i_rst_n)
		s_r.tick |=> !s_r.tick [*3])
		else $error("converter clock period too short");
endmodule

// File: hw/acs_sequencer.sv
// module: conversion sequencer for the 10-bit converter
`timescale 1ns/10ps
module acs_sequencer
	import acs_pkg::*;
#(
	parameter int DIV = ADCLK_MIN_CYC
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// request side
	input wire logic i_soc,
	input wire logic [WIN_W-1:0] i_sample_window_divider,
	input wire logic i_done_clr,
	// analog stage
	input wire logic [RES_W-1:0] i_ana_data,
	output logic o_sample,
	output logic o_convert,
	// results and events
	output logic [RES_W-1:0] o_result,
	output logic o_done,
	output logic o_converter_interrupt
);
	// all sequencer state in one record
	typedef struct packed {
		acs_state_t st;
		logic [7:0] cnt; // core cycles in phase
		logic [5:0] ticks; // converter periods in phase
		logic [5:0] len; // sample window in periods
		logic [7:0] tot; // core cycles since start
		logic [RES_W-1:0] sync1; // first sync stage
		logic [RES_W-1:0] sync2; // second sync stage
		logic [RES_W-1:0] result;
		logic sample;
		logic convert;
		logic done;
		logic irq;
	} acs_seq_t;

	acs_seq_t s_r;
	acs_seq_t s_nxt;
	logic [5:0] win_len; // window length from the field
	logic accept; // request taken this cycle

	acs_div_if div_bus ();

	// prescaled converter clock
	acs_prescaler #(
		.DIV(DIV)
	) u_prescaler (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.bus(div_bus.div)
	);

	// the whole budget must fit the counters
	initial begin
		if (DIV * (SAMPLE_MAX + CONV_TICKS) + 16 > 255) begin
			$error("acs_sequencer: DIV too large for counters");
		end
	end

	// field value n gives n+1 periods, never under two
	always_comb begin
		win_len = 6'(i_sample_window_divider) + 6'h01;
		if (win_len < 6'(SAMPLE_MIN)) begin
			win_len = 6'(SAMPLE_MIN);
		end
	end

	// a request is only taken once the last result is out
	assign accept = (s_r.st == ACS_IDLE) && i_soc;

	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.irq = 1'b0;
		// analog data is asynchronous: two stages first
		s_nxt.sync1 = i_ana_data;
		s_nxt.sync2 = s_r.sync1;
		// total time runs in every phase but idle, flag included, and holds at ff
		if (s_r.st != ACS_IDLE && s_r.tot != 8'hff) begin
			s_nxt.tot = s_r.tot + 8'h01;
		end
		// software clear of the flag; a set below wins
		if (i_done_clr) begin
			s_nxt.done = 1'b0;
		end
		case (s_r.st)
			ACS_IDLE: begin
				if (accept) begin
					s_nxt.st = ACS_START;
					s_nxt.cnt = CNT_RST;
					s_nxt.tot = 8'h01;
					s_nxt.len = win_len;
					s_nxt.done = 1'b0;
				end
			end
			ACS_START: begin
				// hold off sampling for the start delay
				if (s_r.cnt == 8'(START_CYC - 1)) begin
					s_nxt.st = ACS_SAMPLE;
					s_nxt.sample = 1'b1;
					s_nxt.ticks = 6'h00;
				end else begin
					s_nxt.cnt = s_r.cnt + 8'h01;
				end
			end
			ACS_SAMPLE: begin
				// window counted in whole converter periods
				if (div_bus.tick) begin
					if (s_r.ticks + 6'h01 == s_r.len) begin
						s_nxt.st = ACS_CONV;
						s_nxt.sample = 1'b0;
						s_nxt.convert = 1'b1;
						s_nxt.ticks = 6'h00;
					end else begin
						s_nxt.ticks = s_r.ticks + 6'h01;
					end
				end
			end
			ACS_CONV: begin
				// fixed length conversion
				if (div_bus.tick) begin
					if (s_r.ticks == 6'(CONV_TICKS - 1)) begin
						s_nxt.st = ACS_LOAD;
						s_nxt.convert = 1'b0;
						s_nxt.cnt = CNT_RST;
					end else begin
						s_nxt.ticks = s_r.ticks + 6'h01;
					end
				end
			end
			ACS_LOAD: begin
				// load after the delay and once the floor is met
				if (s_r.cnt >= 8'(LOAD_CYC - 1) &&
					s_r.tot >= 8'(TOTAL_MIN_CYC)) begin
					s_nxt.result = s_r.sync2;
					s_nxt.st = ACS_FLAG;
					s_nxt.cnt = CNT_RST;
				end else begin
					s_nxt.cnt = s_r.cnt + 8'h01;
				end
			end
			ACS_FLAG: begin
				// flag follows the load, interrupt follows flag
				s_nxt.done = 1'b1;
				s_nxt.cnt = s_r.cnt + 8'h01;
				if (s_r.cnt == 8'(IRQ_CYC)) begin
					s_nxt.irq = 1'b1;
					s_nxt.st = ACS_IDLE;
				end
			end
			default: begin
				s_nxt.st = ACS_IDLE;
				s_nxt.sample = 1'b0;
				s_nxt.convert = 1'b0;
			end
		endcase
	end

	// state register
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_r <= '0;
			s_r.st <= ACS_IDLE;
			s_r.result <= RESULT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// realign the prescaler on the very edge that opens sampling; a
	// registered restart came a cycle late and let a stale tick count
	assign div_bus.restart = (s_r.st == ACS_START) &&
		(s_r.cnt == 8'(START_CYC - 1));

	// outputs straight from the state register
	assign o_sample = s_r.sample;
	assign o_convert = s_r.convert;
	assign o_result = s_r.result;
	assign o_done = s_r.done;
	assign o_converter_interrupt = s_r.irq;

	// helper counters for the checks below
	logic [7:0] chk_samp;
	logic [7:0] chk_conv;
	logic [7:0] chk_tot;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			chk_samp <= CNT_RST;
			chk_conv <= CNT_RST;
			chk_tot <= CNT_RST;
		end else begin
			chk_samp <= o_sample ? chk_samp + 8'h01 : CNT_RST;
			chk_conv <= o_convert ? chk_conv + 8'h01 : CNT_RST;
			if (accept) begin
				chk_tot <= 8'h01;
			end else if (chk_tot != 8'hff) begin
				chk_tot <= chk_tot + 8'h01;
			end
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	// steps of one conversion
	sequence seq_start_hold;
		!o_sample [*2];
	endsequence
	sequence seq_irq_wait;
		!o_converter_interrupt [*2] ##1 o_converter_interrupt;
	endsequence

	a_start_delay: assert property (accept |=> seq_start_hold)
		else $error("sampling began before the start delay");
	a_sample_min: assert property (
		$fell(o_sample) |-> chk_samp >= 8'(SAMPLE_MIN * DIV))
		else $error("sample window too short");
	a_sample_max: assert property (
		o_sample |-> chk_samp < 8'(SAMPLE_MAX * DIV))
		else $error("sample window too long");
	a_conv_len: assert property (
		$fell(o_convert) |-> chk_conv >= 8'(CONV_TICKS * DIV))
		else $error("conversion too short");
	a_load_delay: assert property (
		$fell(o_convert) |-> !$changed(o_result) [*2])
		else $error("result loaded too early");
	a_irq_delay: assert property (
		$rose(o_done) |-> seq_irq_wait)
		else $error("interrupt not two cycles after flag");
	a_total_time: assert property (
		$changed(o_result) |-> chk_tot >= 8'(TOTAL_MIN_CYC))
		else $error("conversion shorter than floor");
	a_phase_order: assert property (
		$rose(o_convert) |-> $past(o_sample) && !o_sample)
		else $error("conversion did not follow sampling");
	a_no_overlap: assert property (
		s_r.st != ACS_IDLE && i_soc |=> s_r.tot != 8'h01)
		else $error("request accepted mid conversion");
endmodule

// File: sim/acs_ana_model.sv
// analog stage model: hands the converted word back around the load
`timescale 1ns/10ps
module acs_ana_model
	import acs_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// phase from the sequencer and the word to hand back
	input wire logic i_convert,
	input wire logic [RES_W-1:0] i_value,
	output logic [RES_W-1:0] o_data
);
	logic [2:0] hold_r; // cycles of hold left after conversion ends

	// hold four cycles past the end of conversion, then show the inverse,
	// so a late load picks up a wrong word, not a lucky stale one; an early load during conversion still sees the word
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			hold_r <= 3'h0;
		end else if (i_convert) begin
			hold_r <= 3'h4;
		end else if (hold_r != 3'h0) begin
			hold_r <= hold_r - 3'h1;
		end
	end

	// word valid only in conversion and the hold after it
	assign o_data = (i_convert || hold_r != 3'h0) ? i_value : ~i_value;
endmodule

// File: sim/acs_sequencer_tb.sv
// testbench: phase timing and data of the conversion sequencer
`timescale 1ns/10ps
module acs_sequencer_tb;
	import acs_pkg::*;
	localparam int DIV = 4; // shortest legal converter period
	// stimulus
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic soc = 1'b0;
	logic [WIN_W-1:0] win = 5'h01;
	logic done_clr = 1'b0;
	logic [RES_W-1:0] val = 10'h000;
	// observed
	logic [RES_W-1:0] ana_data;
	logic [RES_W-1:0] result;
	logic sample;
	logic convert;
	logic done;
	logic irq;
	// bookkeeping
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;

	always #5 core_clk = ~core_clk;

	acs_sequencer #(.DIV(DIV)) u_acs_sequencer (
		.i_core_clk(core_clk),
		.i_rst_n(rst_n),
		.i_soc(soc),
		.i_sample_window_divider(win),
		.i_done_clr(done_clr),
		.i_ana_data(ana_data),
		.o_sample(sample),
		.o_convert(convert),
		.o_result(result),
		.o_done(done),
		.o_converter_interrupt(irq)
	);

	acs_ana_model u_acs_ana_model (
		.i_core_clk(core_clk),
		.i_rst_n(rst_n),
		.i_convert(convert),
		.i_value(val),
		.o_data(ana_data)
	);

	task automatic results;
		if (mismatches == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// watchdog: a whole run needs well under a thousand cycles
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches = mismatches + 1;
			results();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %0h, seen %0h", name, exp, got);
		end
	endtask

	// inputs always move one step after the rising edge
	task automatic step;
		@(posedge core_clk);
		#1;
	endtask

	// one conversion, edge of each phase recorded in cycles from accept;
	// poke raises a request mid-run and in the flag cycle, which must
	// leave no trace, and clears the flag on the edge that sets it
	task automatic run_conv(input logic [WIN_W-1:0] field,
		input logic [RES_W-1:0] word, input bit poke);
		int len, ts, te, tc, tr, td, ti, tj;
		len = (field < 5'h01) ? 2 : int'(field) + 1;
		ts = -1; te = -1; tc = -1; tr = -1; td = -1; ti = -1; tj = -1;
		val = word;
		win = field;
		soc = 1'b1;
		step();
		soc = 1'b0;
		chk("flag on accept", 0, done);
		for (int c = 1; c < 600 && tj < 0; c++) begin
			step();
			if (sample && ts < 0) ts = c;
			if (!sample && ts >= 0 && te < 0) te = c;
			if (!convert && te >= 0 && tc < 0) tc = c;
			if (result === word && tc >= 0 && tr < 0) tr = c;
			if (done && td < 0) td = c;
			if (irq && ti < 0) ti = c;
			if (!irq && ti >= 0 && tj < 0) tj = c;
			soc = poke && (c == 20 || c == td);
			done_clr = poke && c == tr;
		end
		chk("sample start", START_CYC, ts);
		chk("sample length", len * DIV, te - ts);
		chk("convert length", 10 * DIV, tc - te);
		chk("result load", (tc + 2 < 50) ? 50 : tc + 2, tr);
		chk("result word", word, result);
		chk("flag set", tr + 1, td);
		chk("interrupt delay", td + 2, ti);
		chk("interrupt width", 1, tj - ti);
		// a request taken while busy would start a sampling phase here
		for (int c = 0; c < 10 && poke; c++) begin
			step();
			chk("busy request", 0, sample);
		end
	endtask

	// flag stays until cleared by the dedicated input or by a newly accepted request
	task automatic clear_flag;
		chk("flag held", 1, done);
		done_clr = 1'b1;
		step();
		done_clr = 1'b0;
		chk("flag cleared", 0, done);
	endtask

	task automatic check_reset;
		chk("reset outputs", 0, {sample, convert, irq, done, result});
	endtask

	// main sequence: the last run follows the one before with no gap
	initial begin
		repeat (6) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
		check_reset();
		run_conv(5'h01, 10'h2a5, 1'b0);
		clear_flag();
		run_conv(5'h00, 10'h15a, 1'b1);
		run_conv(5'h1f, 10'h3c3, 1'b0);
		run_conv(5'h07, 10'h0f0, 1'b0);
		results();
	end
endmodule
